// file: pkg/cer_regs.svh
// Register offsets, field positions and reset values of the
// correctable error reporting block.
// Assumes byte addresses on a 32-bit register bus, one word per register.
`ifndef CER_REGS_SVH
`define CER_REGS_SVH

// ********************************
// Byte offsets
// ********************************
`define CER_OFS_FLAGS 12'h110
`define CER_OFS_SUPPRESS 12'h114
`define CER_OFS_CAPCTL 12'h118
`define CER_OFS_LOG0 12'h11C
`define CER_OFS_LOG3 12'h128

// ********************************
// Fields and reset values
// ********************************
`define CER_BIT_RXERR 0
`define CER_BIT_BADTLP 6
`define CER_BIT_BADDLLP 7
`define CER_BIT_ROLL 8
`define CER_BIT_RTMO 12
`define CER_BIT_ADV 13
`define CER_FEP_MSB 4
`define CER_FEP_LSB 0
`define CER_GEN_CAP 5
`define CER_GEN_EN 6
`define CER_CHK_CAP 7
`define CER_CHK_EN 8
`define CER_IMPL 32'h0000_31C1
`define CER_FLAGS_RST 32'h0000_0000
`define CER_SUP_RST 32'h0000_2000
`endif

// file: pkg/cer_pkg.sv
// Types of the correctable error reporting block.
// Assumes the constants header is included by the modules.
package cer_pkg;
   typedef enum logic [2:0] {
      CER_IDLE = 3'b000,
      CER_RLOG = 3'b001,
      CER_RRESP = 3'b010,
      CER_BRESP = 3'b011
   } cer_bus_st_t;

   typedef struct packed {
      cer_bus_st_t st;
      logic aw_have;
      logic w_have;
      logic [11:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic arready;
      logic bvalid;
      logic rvalid;
      logic [1:0] bresp;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [31:0] flags;
      logic [31:0] suppress;
      logic [4:0] first_ptr;
      logic gen_en;
      logic chk_en;
      logic log_busy;
      logic [31:0] log_bits;
      logic err_msg;
   } cer_state_t;
endpackage

// file: pkg/cer_if.sv
// Carriers between the top of the block and its two helpers.
// Assumes all ends run on the same clock.
`timescale 1ns/1ns
interface cer_evt_if;
   logic [31:0] evt;
   logic [127:0] hdr;
   modport src (output evt, output hdr);
   modport snk (input evt, input hdr);
endinterface

interface cer_log_if;
   logic wr_en;
   logic [127:0] wr_data;
   logic [1:0] rd_idx;
   logic [31:0] rd_data;
   modport mem (input wr_en, input wr_data, input rd_idx, output rd_data);
   modport user (output wr_en, output wr_data, output rd_idx, input rd_data);
endinterface

// file: logic/cer_evt_map.sv
// Places event pulses on their flag positions and orders header bytes.
// Assumes event pulses and header bytes come from logic on the same clock.
`timescale 1ns/1ns
`include "cer_regs.svh"
module cer_evt_map (
   input wire logic [5:0] err_evt,
   input wire logic [15:0][7:0] pkt_hdr,
   cer_evt_if.src bus
);
   localparam int POS [6] = '{`CER_BIT_RXERR, `CER_BIT_BADTLP, `CER_BIT_BADDLLP,
      `CER_BIT_ROLL, `CER_BIT_RTMO, `CER_BIT_ADV};

   logic [31:0] evt;

   always_comb begin
      evt = 32'h0000_0000;
      for (int i = 0; i < 6; i++) begin
         evt[POS[i]] = err_evt[i];
      end
   end
   assign bus.evt = evt;

   for (genvar k = 0; k < 4; k++) begin : g_dw
      assign bus.hdr[32*k +: 32] = {pkt_hdr[4*k], pkt_hdr[4*k+1],
         pkt_hdr[4*k+2], pkt_hdr[4*k+3]};
   end
endmodule

// file: logic/cer_hdr_mem.sv
// Header log storage: whole-row write, one word read through a register.
// Assumes only power-on reset reaches it, so the content is sticky.
`timescale 1ns/1ns
module cer_hdr_mem #(
   parameter int WORDS = 4
) (
   input wire logic clk,
   input wire logic nrst,
   cer_log_if.mem bus
);
   typedef struct packed {
      logic [WORDS-1:0][31:0] word;
      logic [31:0] rd_data;
   } cer_mem_t;

   cer_mem_t q, n;

   always_comb begin
      n = q;
      n.rd_data = q.word[bus.rd_idx];
      if (bus.wr_en) begin
         n.word = bus.wr_data;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign bus.rd_data = q.rd_data;
endmodule

// file: logic/cer_top.sv
// Correctable error reporting registers with an AXI4-Lite slave.
// Assumes event pulses, header bytes and the first error pointer come
// from logic on clk; nrst is the power-on reset, link_rst_n the ordinary one.
`timescale 1ns/1ns
`include "cer_regs.svh"
module cer_top (
   input wire logic clk,
   input wire logic nrst,
   input wire logic link_rst_n,
   input wire logic [5:0] err_evt,
   input wire logic [15:0][7:0] pkt_hdr,
   input wire logic fep_load,
   input wire logic [4:0] fep_val,
   output logic err_msg,
   output logic ecrc_gen_en,
   output logic ecrc_chk_en,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import cer_pkg::*;

   // ********************************
   // Register map
   // ********************************
   // 0x110 flags: write one to clear, sticky
   //    bits 0, 6, 7, 8, 12 and 13 are implemented, the rest read zero
   //    a flag sets even while its suppress bit is set
   // 0x114 suppress: read and write, sticky
   //    same implemented bits as the flags
   //    bit 13 is set after power-on, so advisory events stay quiet
   // 0x118 capability and control
   //    4:0 first error pointer, loaded only through fep_load
   //    5 and 7 always read one
   //    6 and 8 are the CRC enables, byte lanes 0 and 1 respectively
   // 0x11C to 0x128 header log: four read-only words
   //    writes answer OKAY and change nothing
   // Every other word answers SLVERR, reads zero and ignores writes
   //
   // Timing seen from the bus
   //    plain register read: data one cycle after the address edge
   //    header log read: one more cycle, for the memory output register
   //    write: response one cycle after the later of address and data
   //
   // A read waiting together with a complete write is served first,
   // so an endless stream of reads could hold a write off; the
   // intended master issues one request at a time, so this is accepted
   //
   // The log word passes through the memory's output register, which
   // keeps the 128-bit store out of the read data path at the cost of
   // one extra cycle on header reads
   //
   // Only nrst resets state; link_rst_n only silences error pulses

   // ********************************
   // Constants and declarations
   // ********************************
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam cer_state_t RST_VAL = '{
      st: CER_IDLE,
      suppress: `CER_SUP_RST,
      flags: `CER_FLAGS_RST,
      default: '0
   };

   cer_state_t q;
   cer_state_t n;
   cer_evt_if evt_bus ();
   cer_log_if log_bus ();

   logic aw_fire;
   logic w_fire;
   logic ar_fire;
   logic ar_log;
   logic [31:0] wmask;
   logic [31:0] wr_clr;
   logic [31:0] wr_sup;
   logic [31:0] unmasked;
   logic [11:0] log_ofs;

   // ********************************
   // Helpers
   // ********************************
   cer_evt_map u_map (
      .err_evt(err_evt),
      .pkt_hdr(pkt_hdr),
      .bus(evt_bus)
   );

   cer_hdr_mem #(
      .WORDS(4)
   ) u_mem (
      .clk(clk),
      .nrst(nrst),
      .bus(log_bus)
   );

   // ********************************
   // Decode functions
   // ********************************
   function automatic logic [31:0] strb_mask(input logic [3:0] s);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
         m[8*i +: 8] = {8{s[i]}};
      end
      return m;
   endfunction

   function automatic logic is_log(input logic [11:0] a);
      logic [11:0] w;
      w = {a[11:2], 2'b00};
      return (w >= `CER_OFS_LOG0) && (w <= `CER_OFS_LOG3);
   endfunction

   function automatic logic is_mapped(input logic [11:0] a);
      logic [11:0] w;
      w = {a[11:2], 2'b00};
      return (w == `CER_OFS_FLAGS) || (w == `CER_OFS_SUPPRESS) ||
         (w == `CER_OFS_CAPCTL) || is_log(a);
   endfunction

   // Word image of the plain registers; header words come from memory
   // Reserved positions stay zero because cap starts from zero and
   // flags and suppress only ever hold implemented bits
   function automatic logic [31:0] reg_word(input cer_state_t s, input logic [11:0] a);
      logic [11:0] w;
      logic [31:0] cap;
      w = {a[11:2], 2'b00};
      cap = 32'h0000_0000;
      cap[`CER_FEP_MSB:`CER_FEP_LSB] = s.first_ptr;
      cap[`CER_GEN_CAP] = 1'b1;
      cap[`CER_GEN_EN] = s.gen_en;
      cap[`CER_CHK_CAP] = 1'b1;
      cap[`CER_CHK_EN] = s.chk_en;
      case (w)
         `CER_OFS_FLAGS: begin
            return s.flags;
         end
         `CER_OFS_SUPPRESS: begin
            return s.suppress;
         end
         `CER_OFS_CAPCTL: begin
            return cap;
         end
         default: begin
            return 32'h0000_0000;
         end
      endcase
   endfunction

   // ********************************
   // Next state
   // ********************************
   // Order inside this process matters:
   // first the bus holding slots, then the bus state machine, whose
   // write decode yields the clear mask, then error recording, which
   // merges events with that clear so that a new event wins
   always_comb begin
      n = q;
      aw_fire = q.awready & s_axi_awvalid;
      w_fire = q.wready & s_axi_wvalid;
      ar_fire = q.arready & s_axi_arvalid;
      ar_log = is_log(s_axi_araddr);
      log_ofs = s_axi_araddr - `CER_OFS_LOG0;
      wmask = 32'h0000_0000;
      wr_clr = 32'h0000_0000;
      wr_sup = 32'h0000_0000;
      n.err_msg = 1'b0;
      log_bus.wr_en = 1'b0;
      log_bus.wr_data = evt_bus.hdr;
      // Memory samples the index at the address handshake edge
      log_bus.rd_idx = log_ofs[3:2];

      // Address and data are held separately, so either may come first
      if (aw_fire) begin
         n.aw_have = 1'b1;
         n.waddr = s_axi_awaddr;
      end
      if (w_fire) begin
         n.w_have = 1'b1;
         n.wdata = s_axi_wdata;
         n.wstrb = s_axi_wstrb;
      end

      case (q.st)
         CER_IDLE: begin
            // A read accepted together with a write is served first
            if (ar_fire) begin
               if (ar_log) begin
                  n.st = CER_RLOG;
               end else begin
                  n.st = CER_RRESP;
                  n.rvalid = 1'b1;
                  n.rdata = reg_word(q, s_axi_araddr);
                  n.rresp = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
               end
            end else if (n.aw_have && n.w_have) begin
               wmask = strb_mask(n.wstrb);
               case ({n.waddr[11:2], 2'b00})
                  `CER_OFS_FLAGS: begin
                     wr_clr = n.wdata & wmask & `CER_IMPL;
                  end
                  `CER_OFS_SUPPRESS: begin
                     wr_sup = wmask & `CER_IMPL;
                     n.suppress = (q.suppress & ~wr_sup) | (n.wdata & wr_sup);
                  end
                  `CER_OFS_CAPCTL: begin
                     if (n.wstrb[0]) begin
                        n.gen_en = n.wdata[`CER_GEN_EN];
                     end
                     if (n.wstrb[1]) begin
                        n.chk_en = n.wdata[`CER_CHK_EN];
                     end
                  end
                  default: begin
                     wr_clr = 32'h0000_0000;
                  end
               endcase
               n.aw_have = 1'b0;
               n.w_have = 1'b0;
               n.bvalid = 1'b1;
               n.bresp = is_mapped(n.waddr) ? RESP_OKAY : RESP_SLVERR;
               n.st = CER_BRESP;
            end
         end
         CER_RLOG: begin
            n.rvalid = 1'b1;
            n.rdata = log_bus.rd_data;
            n.rresp = RESP_OKAY;
            n.st = CER_RRESP;
         end
         CER_RRESP: begin
            if (s_axi_rready) begin
               n.rvalid = 1'b0;
               n.st = CER_IDLE;
            end
         end
         CER_BRESP: begin
            if (s_axi_bready) begin
               n.bvalid = 1'b0;
               n.st = CER_IDLE;
            end
         end
         default: begin
            n.st = CER_IDLE;
         end
      endcase

      // Write readies are offered only while the matching holding slot is free, arready only in idle
      n.awready = ~n.aw_have;
      n.wready = ~n.w_have;
      n.arready = (n.st == CER_IDLE);

      // ********************************
      // Error recording
      // ********************************
      // A new event wins over a clear written in the same cycle
      n.flags = (q.flags & ~wr_clr) | evt_bus.evt;

      // The log frees itself once software has cleared every logged flag
      if (q.log_busy && ((n.flags & q.log_bits) == 32'h0000_0000)) begin
         n.log_busy = 1'b0;
      end

      // Masked events still set their flag but stay silent
      unmasked = evt_bus.evt & ~q.suppress;
      if (unmasked != 32'h0000_0000) begin
         // No message is raised while the ordinary reset holds the link
         n.err_msg = link_rst_n;
         if (!n.log_busy) begin
            log_bus.wr_en = 1'b1;
            n.log_busy = 1'b1;
            n.log_bits = unmasked;
         end
      end

      if (fep_load) begin
         n.first_ptr = fep_val;
      end
   end

   // ********************************
   // State register
   // ********************************
   // Only power-on reset touches the sticky state
   // The reset value is a constant image, so the asynchronous branch
   // never depends on other state
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         q <= RST_VAL;
      end else begin
         q <= n;
      end
   end

   // ********************************
   // Outputs
   // ********************************
   // Every output is a field of the state register, never logic
   assign err_msg = q.err_msg;
   assign ecrc_gen_en = q.gen_en;
   assign ecrc_chk_en = q.chk_en;
   assign s_axi_awready = q.awready;
   assign s_axi_wready = q.wready;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = q.arready;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;
endmodule

// file: dv/cer_rc_model.sv
// Root complex end of the port: counts error message pulses.
// Assumes the pulses are registered on clk, one cycle per message.
`timescale 1ns/1ns
module cer_rc_model (
   input wire logic clk,
   input wire logic nrst,
   input wire logic err_msg,
   output int msgs
);
   // Back-to-back high cycles are separate messages, so count every cycle
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) msgs <= 0;
      else if (err_msg) msgs <= msgs + 1;
   end
endmodule

// file: dv/cer_top_assertions.sv
// Port-level checks of cer_top: bus answer timing and error pulses.
// Assumes it is bound to cer_top and sees only its ports.
`timescale 1ns/1ns
module cer_top_assertions (
   input wire logic clk,
   input wire logic nrst,
   input wire logic link_rst_n,
   input wire logic [5:0] err_evt,
   input wire logic err_msg,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // ********************************
   // Sequences and properties
   // ********************************
   sequence s_ar(lo, hi);
      s_axi_arvalid && s_axi_arready && s_axi_araddr >= lo && s_axi_araddr <= hi;
   endsequence
   property p_msg_cause;
      err_msg |-> $past(|err_evt) && $past(link_rst_n);
   endproperty
   a_msg_cause: assert property (p_msg_cause) else $error("pulse without event");
   property p_link_quiet;
      !link_rst_n |=> !err_msg;
   endproperty
   a_link_quiet: assert property (p_link_quiet) else $error("pulse in link reset");
   property p_reg_lat;
      s_ar(12'h110, 12'h11b) |=> s_axi_rvalid && s_axi_rresp == 2'b00;
   endproperty
   a_reg_lat: assert property (p_reg_lat) else $error("register read late");
   property p_cap_bits;
      s_ar(12'h118, 12'h11b) |=> s_axi_rdata[7] && s_axi_rdata[5] && s_axi_rdata[31:9] == 0;
   endproperty
   a_cap_bits: assert property (p_cap_bits) else $error("capability bits wrong");
   property p_flag_rsvd;
      s_ar(12'h110, 12'h113) |=> s_axi_rdata[31:14] == 0 && s_axi_rdata[11:9] == 0
         && s_axi_rdata[5:1] == 0;
   endproperty
   a_flag_rsvd: assert property (p_flag_rsvd) else $error("reserved flag bits set");
   property p_log_lat;
      s_ar(12'h11c, 12'h12b) |=> !s_axi_rvalid ##1 s_axi_rvalid && s_axi_rresp == 2'b00;
   endproperty
   a_log_lat: assert property (p_log_lat) else $error("log read timing wrong");
   property p_rd_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
   property p_wr_resp;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
   endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("write response late");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
endmodule

bind cer_top cer_top_assertions cer_top_assertions_inst (.*);

// file: dv/cer_top_test.sv
// Self-checking bench of cer_top: bus master, event driver and an
// integer model of flags, suppress bits, control word and header log.
// Assumes the root complex model and the checker are compiled first.
`timescale 1ns/1ns
`include "cer_regs.svh"
module cer_top_test;
   import cer_pkg::*;
   logic clk = 0, nrst = 0, link_rst_n = 1, fep_load = 0, err_msg;
   logic [5:0] err_evt = 0;
   logic [15:0][7:0] pkt_hdr = 0;
   logic [4:0] fep_val = 0;
   logic ecrc_gen_en, ecrc_chk_en;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int n_mismatch = 0, checked = 0, rc_msgs, r;
   int flags = 0, sup = `CER_SUP_RST, gen = 0, chk_e = 0, fep = 0, owners = 0, msgs = 0;
   logic [127:0] logm = 0;
   int pos[6] = '{0, 6, 7, 8, 12, 13};

   cer_top cer_top_inst (.*);
   cer_rc_model cer_rc_model_inst (.clk, .nrst, .err_msg, .msgs(rc_msgs));

   always #25 clk = ~clk;

   // ********************************
   // Tasks
   // ********************************
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task close_out;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   function automatic logic [31:0] resp(input logic [11:0] a);
      return (a >= 12'h110 && a <= 12'h12b) ? 32'h0 : 32'h2;
   endfunction

   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      int n;
      n = 0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 0;
         if (!s_axi_rready) s_axi_rready <= 1'($urandom % 2);
      end while (!(s_axi_rvalid && s_axi_rready) && n < 40);
      s_axi_rready <= 0;
      chk($sformatf("rresp %h", a), 32'(s_axi_rresp), resp(a));
      chk($sformatf("rdata %h", a), s_axi_rdata, e);
   endtask

   task automatic wm(input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
         if (!s_axi_bready) s_axi_bready <= 1'($urandom % 2);
      end while (!(s_axi_bvalid && s_axi_bready) && n < 40);
      s_axi_bready <= 0;
      chk($sformatf("bresp %h", a), 32'(s_axi_bresp), resp(a));
      if (a == 12'h110) flags &= ~d;
      if (a == 12'h114) sup = d & `CER_IMPL;
      if (a == 12'h118) begin
         gen = d[6];
         chk_e = d[8];
      end
      // The log frees only once every bit that caused the capture is gone
      if ((flags & owners) == 0) owners = 0;
      @(posedge clk);
      chk("ecrc_gen_en", 32'(ecrc_gen_en), gen);
      chk("ecrc_chk_en", 32'(ecrc_chk_en), chk_e);
   endtask

   task automatic ev(input int i);
      logic [15:0][7:0] h;
      int b;
      h = {$urandom, $urandom, $urandom, $urandom};
      b = pos[i];
      @(posedge clk);
      err_evt <= 6'(1 << i);
      pkt_hdr <= h;
      @(posedge clk);
      err_evt <= 0;
      if (!sup[b] && owners == 0) begin
         owners = 1 << b;
         for (int k = 0; k < 16; k++) logm[32 * (k / 4) + 8 * (3 - k % 4) +: 8] = h[k];
      end
      flags |= 1 << b;
      if (!sup[b] && link_rst_n) msgs++;
      @(posedge clk);
      chk("err_msg", 32'(err_msg), 32'(!sup[b] && link_rst_n));
   endtask

   task fl(input logic [4:0] v);
      @(posedge clk);
      fep_load <= 1;
      fep_val <= v;
      @(posedge clk);
      fep_load <= 0;
      fep = v;
   endtask

   task check_all;
      rc(12'h110, flags);
      rc(12'h114, sup);
      rc(12'h118, chk_e << 8 | 32'h0000_00a0 | gen << 6 | fep);
      for (int k = 0; k < 4; k++) rc(12'h11c + 12'(4 * k), logm[32 * k +: 32]);
   endtask

   // ********************************
   // Sequence
   // ********************************
   initial begin
      #1_000_000;
      n_mismatch++;
      close_out();
   end

   initial begin
      r = $urandom(32'hd894_304b);
      repeat (3) @(posedge clk);
      nrst <= 1;
      @(posedge clk);
      check_all();
      rc(12'h100, 0);
      wm(12'h100, 32'hffff_ffff);
      wm(12'h11c, 32'hffff_ffff);
      check_all();
      $display("test 1 done");
      for (int i = 0; i < 6; i++) ev(i);
      wm(12'h110, 32'h0000_0040);
      ev(2);
      check_all();
      wm(12'h110, 32'h0000_0001);
      ev(3);
      wm(12'h110, 32'h0000_0000);
      check_all();
      $display("test 2 done");
      for (int t = 0; t < 30; t++) begin
         case ($urandom % 5)
            0: wm(12'h114, $urandom);
            1: wm(12'h110, $urandom);
            2: wm(12'h118, $urandom);
            3: fl(5'($urandom));
            default: begin
               link_rst_n <= ($urandom % 4) != 0;
               ev($urandom % 6);
            end
         endcase
         check_all();
      end
      link_rst_n <= 1;
      @(posedge clk);
      chk("messages", rc_msgs, msgs);
      $display("test 3 done");
      close_out();
   end
endmodule
